// ===== verilog/apc_pkg.sv
`default_nettype none

package apc_pkg;

	// ==========================================================
	// Widths and depths
	localparam int DATA_W     = 12;
	localparam int TAG_W      = 2;
	localparam int FIFO_W     = DATA_W + TAG_W;
	localparam int FIFO_DEPTH = 32;

	// ==========================================================
	// Conversion clock edge counts
	localparam logic [3:0] FALLS_TO_COMPLETE = 4'he;
	localparam logic [3:0] RISES_TO_TRACK    = 4'hd;

	// ==========================================================
	// Acquisition time
	localparam int MCLK_PERIOD_NS = 5;
	localparam int ACQ_TIME_NS    = 125;
	localparam int ACQ_CYCLES     =
		(ACQ_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [4:0] ACQ_COUNT = 5'(ACQ_CYCLES);

	// ==========================================================
	// Control word layout and reset value
	localparam int         PM_LO_POS  = 4;
	localparam int         PM_HI_POS  = 5;
	localparam logic [11:0] CTRL_RESET = 12'h000;

	// Power-management encodings
	localparam logic [1:0] PM_NORMAL        = 2'h0;
	localparam logic [1:0] PM_AUTO_SHUTDOWN = 2'h1;
	localparam logic [1:0] PM_AUTO_STANDBY  = 2'h2;
	localparam logic [1:0] PM_FULL_SHUTDOWN = 2'h3;

	// ==========================================================
	// Data line layout
	localparam int SHARED_BIT8_POS = 8;
	localparam logic [11:0] OE_WORD = 12'hfff;
	localparam logic [11:0] OE_BYTE = 12'h0ff;
	localparam logic [11:0] OE_NONE = 12'h000;

	// ==========================================================
	// Synchroniser vector layout and idle levels
	localparam int SY_CONVERSION_START_N = 0;
	localparam int SY_CCLK   = 1;
	localparam int SY_CS     = 2;
	localparam int SY_RD     = 3;
	localparam int SY_WR     = 4;
	localparam int SY_WB     = 5;
	localparam int SY_DATA   = 6;
	localparam int SY_W      = SY_DATA + DATA_W;
	localparam logic [17:0] SYNC_RESET = 18'h0003d;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {
		CV_IDLE,
		CV_CONVERT,
		CV_STORE,
		CV_DRAIN
	} apc_conv_t;

	typedef enum logic [1:0] {
		PW_ON,
		PW_STANDBY,
		PW_SHUTDOWN
	} apc_power_t;

endpackage

`default_nettype wire

// ===== verilog/apc_sync.sv
`default_nettype none

module apc_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// Raw and filtered levels
	input  wire logic [WIDTH-1:0] rawIn,
	output logic      [WIDTH-1:0] level
);

	// ==========================================================
	// Three stages; a change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;
			always_ff @(posedge mclk) begin
				if (reset) begin
					stage1 <= RESET_VAL[i];
					stage2 <= RESET_VAL[i];
					stage3 <= RESET_VAL[i];
					level[i] <= RESET_VAL[i];
				end else begin
					stage1 <= rawIn[i];
					stage2 <= stage1;
					stage3 <= stage2;
					if (stage2 == stage3) begin
						level[i] <= stage3;
					end
				end
			end
		end
	endgenerate

endmodule // apc_sync

`default_nettype wire

// ===== verilog/apc_fifo.sv
`default_nettype none

module apc_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int             AW         = $clog2(DEPTH);
	localparam logic [AW:0]    FULL_COUNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0]  LAST_SLOT  = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign inReady  = (count != FULL_COUNT);
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// ==========================================================
	// Storage
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// ==========================================================
	// Pointers and occupancy
	always_ff @(posedge mclk) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == LAST_SLOT) ? '0 : AW'(wrPtr + 1'b1);
			end
			if (pop) begin
				rdPtr <= (rdPtr == LAST_SLOT) ? '0 : AW'(rdPtr + 1'b1);
			end
			if (push && !pop) begin
				count <= (AW + 1)'(count + 1'b1);
			end else if (pop && !push) begin
				count <= (AW + 1)'(count - 1'b1);
			end
		end
	end

endmodule // apc_fifo

`default_nettype wire

// ===== verilog/apc_port.sv
// Behaviour
// RQ1: Data port is 12 bits; word/byte select high means word mode.
// RQ2: Start falling edge begins conversion, holds sampler, raises busy.
// RQ3: Start rising before 14th conversion clock fall aborts, sampler tracks.
// RQ4: Busy goes low when the conversion completes; here a full queue holds busy high until the host reads.
// RQ5: After power-on sampler holds until first start rising edge.
// RQ6: Host allows 125 ns acquisition before lowering start.
// RQ7: Sampler holds on start fall, tracks on 13th conversion clock rise.
// RQ8: In auto power-down modes a start rising edge powers up.
// RQ9: Word mode read drives all 12 result bits; shared pin is bit 8.
// RQ10: Byte mode read uses two eight-bit reads chosen by high-byte enable.
// RQ11: Low byte is eight LSBs; high byte is MSBs, channel tag, zeros.
// RQ12: Select and read strobe combine; lines driven only while both low.
// RQ13: Lines released once the read access ends.
// RQ14: With strobes held low, new result is on lines before busy falls; here in byte mode it waits behind an unread result.
// RQ15: Host avoids toggling read strobe during conversion.
// RQ16: Word mode write loads full control word, bit 0 least significant.
// RQ17: Byte mode write is low byte, then high byte with enable high.
// RQ18: Host writes zeros in the top four bits of the high byte.
// RQ19: Control word latches on rising edge of write strobe.
// RQ20: Select and write strobe combine internally.
// RQ21: Two power bits pick one of four modes; reset gives normal.
// RQ22: Encodings: normal, auto shutdown, auto standby, full shutdown.
// RQ23: Full shutdown and wake from it happen at write strobe rise.
// RQ24: Result and tag register updates only when a conversion completes; here it also loads the next queued result when a read takes the current one.
`default_nettype none

module apc_port
	import apc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// Conversion pins
	input  wire logic              conversionStartN,
	input  wire logic              conversionClockIn,
	output logic                   busy,
	// Bus strobes and mode
	input  wire logic              chipSelectN,
	input  wire logic              readStrobeN,
	input  wire logic              writeStrobeN,
	input  wire logic              wordByteSel,
	// Data lines, bit 8 is the shared pin
	input  wire logic [DATA_W-1:0] dataLinesIn,
	output logic      [DATA_W-1:0] dataLinesOut,
	output logic      [DATA_W-1:0] dataLinesOe,
	// Sampled value from the analogue core
	input  wire logic [DATA_W-1:0] sampleCode,
	input  wire logic [TAG_W-1:0]  sampleChannel,
	// Status
	output logic                   samplerTrack,
	output logic      [1:0]        powerState,
	output logic      [DATA_W-1:0] controlWord,
	output logic                   acquisitionShort
);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [SY_W-1:0] rawPins;
	logic [SY_W-1:0] pins;
	logic [SY_W-1:0] pinsPrev;

	assign rawPins = {dataLinesIn, wordByteSel, writeStrobeN, readStrobeN,
		chipSelectN, conversionClockIn, conversionStartN};

	apc_sync #(
		.WIDTH     (SY_W),
		.RESET_VAL (SYNC_RESET)
	) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.rawIn (rawPins),
		.level (pins)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			pinsPrev <= SYNC_RESET;
		end else begin
			pinsPrev <= pins;
		end
	end

	logic            convFall;
	logic            convRise;
	logic            clkRise;
	logic            clkFall;
	logic            readActive;
	logic            writeActive;
	logic            wordMode;
	logic            highByteEnable;
	logic [DATA_W-1:0] busData;

	assign convFall = pinsPrev[SY_CONVERSION_START_N] && !pins[SY_CONVERSION_START_N];
	assign convRise = !pinsPrev[SY_CONVERSION_START_N] && pins[SY_CONVERSION_START_N];
	assign clkRise  = !pinsPrev[SY_CCLK] && pins[SY_CCLK];
	assign clkFall  = pinsPrev[SY_CCLK] && !pins[SY_CCLK];
	assign readActive  = !pins[SY_CS] && !pins[SY_RD];  // see RQ12
	assign writeActive = !pins[SY_CS] && !pins[SY_WR];  // see RQ20
	assign wordMode    = pins[SY_WB];                   // see RQ1
	assign busData     = pins[SY_DATA +: DATA_W];
	assign highByteEnable = busData[SHARED_BIT8_POS];

	logic readActPrev;
	logic writeActPrev;
	logic readHigh;
	logic readEnd;
	logic writeEnd;

	assign readEnd  = readActPrev && !readActive;
	assign writeEnd = writeActPrev && !writeActive;  // see RQ19

	always_ff @(posedge mclk) begin
		if (reset) begin
			readActPrev  <= 1'b0;
			writeActPrev <= 1'b0;
			readHigh     <= 1'b0;
		end else begin
			readActPrev  <= readActive;
			writeActPrev <= writeActive;
			if (readActive) begin
				readHigh <= highByteEnable;
			end
		end
	end

	// ==========================================================
	// Control word writes
	logic [7:0]        lowStage;
	logic              ctrlCommit;
	logic [DATA_W-1:0] ctrlNew;
	logic [1:0]        pmNow;
	logic [1:0]        pmNew;

	always_comb begin
		ctrlCommit = 1'b0;
		ctrlNew    = controlWord;
		if (writeEnd && wordMode) begin
			ctrlCommit = 1'b1;
			ctrlNew    = busData;  // see RQ16
		end else if (writeEnd && highByteEnable) begin
			ctrlCommit = 1'b1;
			ctrlNew    = {busData[3:0], lowStage};  // see RQ17
		end
	end

	assign pmNow = {controlWord[PM_HI_POS], controlWord[PM_LO_POS]};
	assign pmNew = {ctrlNew[PM_HI_POS], ctrlNew[PM_LO_POS]};

	always_ff @(posedge mclk) begin
		if (reset) begin
			controlWord <= CTRL_RESET;  // see RQ21
			lowStage    <= 8'h00;
		end else begin
			if (writeEnd && !wordMode && !highByteEnable) begin
				lowStage <= busData[7:0];  // see RQ17
			end
			if (ctrlCommit) begin
				controlWord <= ctrlNew;
			end
		end
	end

	// ==========================================================
	// Conversion sequence
	apc_conv_t       state;
	logic [3:0]      fallCount;
	logic [3:0]      riseCount;
	logic [FIFO_W-1:0] captured;
	logic            primed;
	logic            startConv;
	logic            abortConv;
	logic            convDone;
	logic            fifoInReady;
	logic            fifoOutValid;
	logic [FIFO_W-1:0] fifoOutData;
	logic            loadOut;
	logic            loadPrev;

	// Power-on hold until the first start rising edge
	assign startConv = (state == CV_IDLE) && convFall && primed
		&& (powerState == PW_ON);  // see RQ5
	assign abortConv = (state == CV_CONVERT) && convRise
		&& (fallCount < FALLS_TO_COMPLETE);  // see RQ3
	// Busy drops once no load is in flight; a result queued behind an
	// unread one waits in the queue instead of stalling busy
	assign convDone = (state == CV_DRAIN) && !loadOut && !loadPrev;

	always_ff @(posedge mclk) begin
		if (reset) begin
			primed <= 1'b0;
		end else if (convRise) begin
			primed <= 1'b1;  // see RQ5
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state     <= CV_IDLE;
			busy      <= 1'b0;
			fallCount <= 4'h0;
			riseCount <= 4'h0;
			captured  <= '0;
		end else begin
			unique case (state)
				CV_IDLE: begin
					if (startConv) begin
						state     <= CV_CONVERT;
						busy      <= 1'b1;  // see RQ2
						fallCount <= 4'h0;
						riseCount <= 4'h0;
						captured  <= {sampleChannel, sampleCode};
					end
				end
				CV_CONVERT: begin
					if (abortConv) begin
						state <= CV_IDLE;
						busy  <= 1'b0;  // see RQ3
					end else begin
						if (clkRise) begin
							riseCount <= 4'(riseCount + 1'b1);
						end
						if (clkFall) begin
							fallCount <= 4'(fallCount + 1'b1);
							if (fallCount == FALLS_TO_COMPLETE - 4'h1) begin
								state <= CV_STORE;
							end
						end
					end
				end
				CV_STORE: begin
					// A full queue holds busy high until the host reads
					if (fifoInReady) begin
						state <= CV_DRAIN;
					end
				end
				CV_DRAIN: begin
					if (convDone) begin
						state <= CV_IDLE;
						busy  <= 1'b0;  // see RQ4
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Sampler track and hold
	always_ff @(posedge mclk) begin
		if (reset) begin
			samplerTrack <= 1'b0;  // see RQ5
		end else if (startConv) begin
			samplerTrack <= 1'b0;  // see RQ7
		end else if (abortConv) begin
			samplerTrack <= 1'b1;  // see RQ3
		end else if (state == CV_CONVERT && clkRise
			&& riseCount == RISES_TO_TRACK - 4'h1) begin
			samplerTrack <= 1'b1;  // see RQ7
		end else if (ctrlCommit && pmNew == PM_FULL_SHUTDOWN) begin
			samplerTrack <= 1'b0;  // see RQ23
		end else if (ctrlCommit && powerState == PW_SHUTDOWN
			&& pmNow == PM_FULL_SHUTDOWN) begin
			samplerTrack <= 1'b1;  // see RQ23
		end else if (convDone && (pmNow == PM_AUTO_SHUTDOWN
			|| pmNow == PM_AUTO_STANDBY)) begin
			samplerTrack <= 1'b0;
		end else if (convRise && pmNow != PM_FULL_SHUTDOWN
			&& (!primed || powerState != PW_ON)) begin
			samplerTrack <= 1'b1;  // see RQ8
		end
	end

	// ==========================================================
	// Power modes
	always_ff @(posedge mclk) begin
		if (reset) begin
			powerState <= PW_ON;  // see RQ21
		end else if (ctrlCommit && pmNew == PM_FULL_SHUTDOWN) begin
			powerState <= PW_SHUTDOWN;  // see RQ23
		end else if (ctrlCommit && pmNow == PM_FULL_SHUTDOWN) begin
			powerState <= PW_ON;  // see RQ23
		end else if (convDone && pmNow == PM_AUTO_SHUTDOWN) begin
			powerState <= PW_SHUTDOWN;  // see RQ22
		end else if (convDone && pmNow == PM_AUTO_STANDBY) begin
			powerState <= PW_STANDBY;  // see RQ22
		end else if (convRise && powerState != PW_ON
			&& pmNow != PM_FULL_SHUTDOWN) begin
			powerState <= PW_ON;  // see RQ8
		end
	end

	// ==========================================================
	// Acquisition check, a warning only: the host owns this time
	logic [4:0] acqCount;

	always_ff @(posedge mclk) begin
		if (reset) begin
			acqCount         <= 5'h00;
			acquisitionShort <= 1'b0;
		end else begin
			if (!samplerTrack) begin
				acqCount <= 5'h00;
			end else if (acqCount != ACQ_COUNT) begin
				acqCount <= 5'(acqCount + 1'b1);
			end
			if (startConv) begin
				acquisitionShort <= (acqCount < ACQ_COUNT);  // see RQ6
			end
		end
	end

	// ==========================================================
	// Result queue and output register
	logic              outValid;
	logic [FIFO_W-1:0] outReg;
	logic              readTaken;
	logic              drainReady;

	// Byte mode counts a result as read after its high byte
	assign readTaken  = readEnd && (wordMode || readHigh);  // see RQ10
	// In word mode held-low strobes take each result as it completes, so a read
	// that spans a completion can see the data change
	assign drainReady = !outValid || readTaken
		|| (readActive && wordMode && state == CV_DRAIN);  // see RQ14
	assign loadOut    = fifoOutValid && drainReady;

	apc_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.reset    (reset),
		.inValid  (state == CV_STORE),
		.inReady  (fifoInReady),
		.inData   (captured),
		.outValid (fifoOutValid),
		.outReady (drainReady),
		.outData  (fifoOutData)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			outReg   <= '0;
			outValid <= 1'b0;
			loadPrev <= 1'b0;
		end else begin
			loadPrev <= loadOut;
			if (loadOut) begin
				outReg   <= fifoOutData;  // see RQ24
				outValid <= 1'b1;
			end else if (readTaken) begin
				outValid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Data line drive
	always_ff @(posedge mclk) begin
		if (reset) begin
			dataLinesOut <= '0;
			dataLinesOe  <= OE_NONE;
		end else begin
			if (wordMode) begin
				dataLinesOut <= outReg[DATA_W-1:0];  // see RQ9
			end else if (highByteEnable) begin
				dataLinesOut <= {4'h0, 2'b00, outReg[FIFO_W-1:DATA_W],
					outReg[11:8]};  // see RQ11
			end else begin
				dataLinesOut <= {4'h0, outReg[7:0]};  // see RQ11
			end
			if (!readActive) begin
				dataLinesOe <= OE_NONE;  // see RQ13
			end else begin
				dataLinesOe <= wordMode ? OE_WORD : OE_BYTE;  // see RQ12
			end
		end
	end

	// ==========================================================
	// Checks
	property p_busyStart;
		startConv |=> busy && !samplerTrack;
	endproperty
	a_busyStart: assert property (p_busyStart)  // see RQ2
		else $error("busy or hold missing after start");

	property p_abort;
		abortConv |=> !busy && samplerTrack && state == CV_IDLE;
	endproperty
	a_abort: assert property (p_abort)  // see RQ3
		else $error("early start rise did not abort");

	property p_trackOn13;
		(state == CV_CONVERT && !abortConv && clkRise
			&& riseCount == RISES_TO_TRACK - 4'h1) |=> samplerTrack;
	endproperty
	a_trackOn13: assert property (p_trackOn13)  // see RQ7
		else $error("sampler not tracking after 13th rise");

	property p_resultBeforeBusy;
		$fell(busy) && wordMode && $past(wordMode) |->
			$past(dataLinesOut) == outReg[DATA_W-1:0];
	endproperty
	a_resultBeforeBusy: assert property (p_resultBeforeBusy)  // see RQ14
		else $error("result not on lines before busy fell");

	property p_highByte;
		readActive && !wordMode && highByteEnable |=>
			dataLinesOut[11:6] == 6'h00;
	endproperty
	a_highByte: assert property (p_highByte)  // see RQ11
		else $error("high byte upper bits not zero");

	property p_release;
		!readActive |=> dataLinesOe == OE_NONE;
	endproperty
	a_release: assert property (p_release)  // see RQ13
		else $error("lines still driven after read end");

	property p_fullShutdown;
		ctrlCommit && pmNew == PM_FULL_SHUTDOWN |=>
			powerState == PW_SHUTDOWN && !samplerTrack;
	endproperty
	a_fullShutdown: assert property (p_fullShutdown)  // see RQ23
		else $error("full shutdown not entered at write end");

	property p_autoWake;
		convRise && !ctrlCommit && !convDone && powerState != PW_ON
			&& pmNow != PM_FULL_SHUTDOWN |=> powerState == PW_ON;
	endproperty
	a_autoWake: assert property (p_autoWake)  // see RQ8
		else $error("start rise did not power up");

	property p_outStable;
		!loadOut |=> $stable(outReg);
	endproperty
	a_outStable: assert property (p_outStable)  // see RQ24
		else $error("result register changed without completion");

	property p_wordWrite;
		writeEnd && wordMode |=> controlWord == $past(busData);
	endproperty
	a_wordWrite: assert property (p_wordWrite)  // see RQ16
		else $error("word write not latched");

endmodule // apc_port

`default_nettype wire

// ===== bench/apc_host.sv
`default_nettype none

module apc_host
	import apc_pkg::*;
(
	// Clock
	input  wire logic              mclk,
	// Conversion pins
	output logic                   conversionStartN,
	output logic                   conversionClockIn,
	// Bus strobes and mode
	output logic                   chipSelectN,
	output logic                   readStrobeN,
	output logic                   writeStrobeN,
	output logic                   wordByteSel,
	// Data lines
	output logic      [DATA_W-1:0] dataLinesIn,
	input  wire logic [DATA_W-1:0] dataLinesOut,
	input  wire logic [DATA_W-1:0] dataLinesOe,
	// Analogue value behind the sampler
	output logic      [DATA_W-1:0] sampleCode,
	output logic      [TAG_W-1:0]  sampleChannel
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DATA_W-1:0] hostData;
	logic [DATA_W-1:0] hostOe;
	logic [DATA_W-1:0] floatPat;

	// ==========
	// Wire levels
	// Undriven lines flicker every cycle, so the synchroniser keeps their last steady value
	assign dataLinesIn = (dataLinesOe & dataLinesOut) | (hostOe & hostData)
		| (~(dataLinesOe | hostOe) & floatPat);

	always @(posedge mclk) begin
		floatPat <= ~floatPat;
	end

	initial begin
		{conversionStartN, chipSelectN, readStrobeN, writeStrobeN} = 4'hf;
		{conversionClockIn, wordByteSel} = 2'b01;
		{hostData, hostOe, sampleCode, sampleChannel} = '0;
		floatPat = 12'ha5a;
	end

	// ==========
	// Host actions, each begun just after a falling edge
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic setStart(input logic v);
		conversionStartN = v;
		idle(8);
	endtask

	task automatic setMode(input logic word);
		wordByteSel = word;
		idle(8);
	endtask

	task automatic setRead(input logic v);
		{chipSelectN, readStrobeN} = {v, v};
		idle(8);
	endtask

	task automatic edgeC(input logic v);
		conversionClockIn = v;
		idle(4);
	endtask

	task automatic clockFalls(input int n);
		repeat (n) begin
			edgeC(1'b1);
			edgeC(1'b0);
		end
	endtask

	// Start rises again after the 14th fall, or after fewer falls to abort
	task automatic startConv(input logic [11:0] code, input logic [1:0] tag);
		sampleCode = code;
		sampleChannel = tag;
		idle(30); // Track for 150 ns first
		setStart(1'b0);
	endtask

	// Reads between conversions, or while a full queue holds busy high
	task automatic busRead(input logic hiByte, output logic [11:0] got,
		output logic [11:0] oe);
		hostData = {3'h0, hiByte, 8'h00};
		hostOe = wordByteSel ? OE_NONE : 12'h100;
		{chipSelectN, readStrobeN} = 2'b00;
		idle(8);
		got = dataLinesOut;
		oe = dataLinesOe;
		{chipSelectN, readStrobeN} = 2'b11;
		hostOe = OE_NONE;
		idle(8);
	endtask

	task automatic busWrite(input logic [11:0] d);
		hostData = d;
		hostOe = OE_WORD;
		{chipSelectN, writeStrobeN} = 2'b00;
		idle(8);
		{chipSelectN, writeStrobeN} = 2'b11;
		idle(4);
		hostOe = OE_NONE; // Data held past the rising strobe
		idle(8);
	endtask
endmodule // apc_host

`default_nettype wire

// ===== bench/test_apc_port.sv
`default_nettype none

`define APC_CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) begin \
			errTotal++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module test_apc_port
	import apc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========
	// Signals
	logic              mclk;
	logic              reset;
	logic              conversionStartN;
	logic              conversionClockIn;
	logic              busy;
	logic              chipSelectN;
	logic              readStrobeN;
	logic              writeStrobeN;
	logic              wordByteSel;
	logic [DATA_W-1:0] dataLinesIn;
	logic [DATA_W-1:0] dataLinesOut;
	logic [DATA_W-1:0] dataLinesOe;
	logic [DATA_W-1:0] sampleCode;
	logic [TAG_W-1:0]  sampleChannel;
	logic              samplerTrack;
	logic [1:0]        powerState;
	logic [DATA_W-1:0] controlWord;
	logic              acquisitionShort;
	int                errTotal = 0;
	int                checks = 0;
	int                cycleCount = 0;

	apc_port u_apc_port (.mclk(mclk), .reset(reset),
		.conversionStartN(conversionStartN),
		.conversionClockIn(conversionClockIn), .busy(busy),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .wordByteSel(wordByteSel),
		.dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
		.dataLinesOe(dataLinesOe), .sampleCode(sampleCode),
		.sampleChannel(sampleChannel), .samplerTrack(samplerTrack),
		.powerState(powerState), .controlWord(controlWord),
		.acquisitionShort(acquisitionShort));

	apc_host u_apc_host (.mclk(mclk),
		.conversionStartN(conversionStartN),
		.conversionClockIn(conversionClockIn),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .wordByteSel(wordByteSel),
		.dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
		.dataLinesOe(dataLinesOe), .sampleCode(sampleCode),
		.sampleChannel(sampleChannel));

	always #2.5 mclk = ~mclk;

	// Ceiling well above the expected run of about 7500 cycles
	always @(posedge mclk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			errTotal++;
			completeRun();
		end
	end

	// ==========
	// Scenarios
	task automatic convert(input logic [11:0] code, input logic done,
		output logic [11:0] lastOut);
		int n;
		u_apc_host.startConv(code, code[1:0]);
		u_apc_host.clockFalls(14);
		n = 0;
		lastOut = dataLinesOut;
		while (busy !== 1'b0 && n < 40) begin
			lastOut = dataLinesOut;
			u_apc_host.idle(1);
			n++;
		end
		`APC_CHK(busy, !done);
	endtask

	task automatic testReset();
		`APC_CHK({busy, samplerTrack, dataLinesOe}, 14'h0000);
		`APC_CHK({powerState, controlWord}, {2'h0, CTRL_RESET});
		u_apc_host.setStart(1'b0);
		`APC_CHK(busy, 1'b0);
		u_apc_host.setStart(1'b1);
		`APC_CHK(samplerTrack, 1'b1);
	endtask

	task automatic testFifo();
		logic [11:0] got;
		logic [11:0] oe;
		for (int i = 0; i < 34; i++) begin
			convert(12'h100 + 12'(i), i < 33, got);
			if (i < 33) begin
				u_apc_host.setStart(1'b1);
			end
		end
		for (int i = 0; i < 34; i++) begin
			u_apc_host.busRead(1'b0, got, oe);
			`APC_CHK(got, 12'h100 + 12'(i));
			`APC_CHK(busy, 1'b0);
		end
		u_apc_host.setStart(1'b1);
	endtask

	task automatic testConvert();
		logic [11:0] got;
		logic [11:0] oe;
		u_apc_host.startConv(12'ha5c, 2'h0);
		`APC_CHK({busy, samplerTrack, acquisitionShort}, 3'b100);
		u_apc_host.clockFalls(12);
		`APC_CHK(samplerTrack, 1'b0);
		u_apc_host.edgeC(1'b1);
		u_apc_host.idle(4);
		`APC_CHK(samplerTrack, 1'b1);
		u_apc_host.edgeC(1'b0);
		`APC_CHK(busy, 1'b1);
		convert(12'ha5c, 1'b1, got);
		u_apc_host.setStart(1'b1);
		u_apc_host.startConv(12'h3c3, 2'h3);
		u_apc_host.clockFalls(5);
		u_apc_host.setStart(1'b1);
		`APC_CHK({busy, samplerTrack}, 2'b01);
		u_apc_host.setStart(1'b0); // Start after a short track
		`APC_CHK({busy, acquisitionShort}, 2'b11);
		u_apc_host.setStart(1'b1);
		`APC_CHK({busy, samplerTrack}, 2'b01);
		u_apc_host.busRead(1'b0, got, oe);
		`APC_CHK({oe, got}, {OE_WORD, 12'ha5c});
		`APC_CHK(dataLinesOe, OE_NONE);
	endtask

	task automatic testByte();
		logic [11:0] got;
		logic [11:0] oe;
		u_apc_host.setMode(1'b0);
		convert(12'h9e7, 1'b1, got);
		u_apc_host.setStart(1'b1);
		u_apc_host.busRead(1'b0, got, oe);
		`APC_CHK({oe, got[7:0]}, {OE_BYTE, 8'he7});
		u_apc_host.busRead(1'b1, got, oe);
		`APC_CHK(got[7:0], 8'h39);
		u_apc_host.busWrite(12'h0c4);
		`APC_CHK(controlWord, CTRL_RESET);
		u_apc_host.busWrite(12'h101); // Top nibble left zero
		`APC_CHK(controlWord, 12'h1c4);
		u_apc_host.setMode(1'b1);
	endtask

	task automatic testPower();
		logic [11:0] got;
		logic [11:0] oe;
		u_apc_host.busWrite(12'h8c3);
		`APC_CHK(controlWord, 12'h8c3);
		u_apc_host.busWrite(12'h030);
		`APC_CHK({powerState, samplerTrack}, 3'b100);
		u_apc_host.setStart(1'b0);
		`APC_CHK(busy, 1'b0);
		u_apc_host.setStart(1'b1);
		`APC_CHK({powerState, samplerTrack}, 3'b100);
		u_apc_host.busWrite(12'h000);
		`APC_CHK({powerState, samplerTrack}, 3'b001);
		for (int m = 1; m < 3; m++) begin
			u_apc_host.busWrite({6'h00, 2'(m), 4'h0});
			convert(12'h7a0 + 12'(m), 1'b1, got);
			`APC_CHK({powerState, samplerTrack}, {2'(3 - m), 1'b0});
			u_apc_host.setStart(1'b1);
			`APC_CHK({powerState, samplerTrack}, 3'b001);
			u_apc_host.busRead(1'b0, got, oe);
			`APC_CHK(got, 12'h7a0 + 12'(m));
		end
	endtask

	task automatic testHeld();
		logic [11:0] got;
		u_apc_host.setRead(1'b0);
		convert(12'h6b2, 1'b1, got);
		`APC_CHK(got, 12'h6b2);
		u_apc_host.setRead(1'b1);
		u_apc_host.setStart(1'b1);
	endtask

	task automatic completeRun();
		if (errTotal == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		u_apc_host.idle(2);
		testReset();
		testFifo();
		testConvert();
		testByte();
		testPower();
		testHeld();
		completeRun();
	end
endmodule // test_apc_port

`default_nettype wire
